// ---- rtl/host_read_cache_manager.sv ----
// Read cache policy engine between host requests, disk port and cache store
// Overview of operation
// - Read hit is served from cache memory with no disk access issued.
// - Read miss: fetch from disk, deliver to host, then write into cache.
// - Every entry covers 64 KB, 128 logical blocks, for every logical unit.
// - Per unit read caching enable, set at reset, clearable by management command.
// - Full cache evicts least recently used entry with fewest references.
// - Writes on cached units go to disk and into the cache.
// - Power loss invalidates all entries; old data never hits.
// - Entry count follows installed 16 or 32 MB module.
// - Without module, a reserved shared memory region holds cached data.
// - With module, the shared memory region holds tags and entry state.
module host_read_cache_manager import rcache_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_power_fail,
  input wire logic i_module_present,
  input wire logic i_module_32mb,
  input wire logic i_lun_cfg_valid,
  input wire logic [`RC_LUN_W-1:0] i_lun_cfg_idx,
  input wire logic i_lun_cfg_enable,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [`RC_LUN_W-1:0] i_req_lun,
  input wire logic [`RC_LBA_W-1:0] i_req_lba,
  output logic o_req_ready,
  output logic o_host_done,
  output logic o_host_from_cache,
  output logic o_disk_cmd_valid,
  output logic o_disk_write,
  output logic [`RC_LBA_W-1:0] o_disk_lba,
  input wire logic i_disk_done,
  output logic o_cache_cmd_valid,
  output logic o_cache_write,
  output logic [`RC_IDX_W-1:0] o_cache_entry,
  output logic o_cache_in_shmem,
  output logic o_ctx_in_shmem,
  input wire logic i_cache_done,
  output logic [`RC_LUNS-1:0] o_lun_enabled
);
  rcache_if lk ();

  state_e state, next_state;
  logic wr_q, next_wr_q, disk_ok, next_disk_ok, cache_ok, next_cache_ok;
  logic cfg_ok, next_cfg_ok, cache_in_shmem, next_cache_in_shmem, ctx_in_shmem;
  logic next_ctx_in_shmem;
  key_s key_q, next_key_q;
  cnt_t limit, next_limit;
  idx_t entry, next_entry;
  logic start, next_start, touch, next_touch, fill, next_fill, flush, next_flush;
  logic req_ready, next_req_ready, host_done, next_host_done, from_cache;
  logic next_from_cache, disk_valid, next_disk_valid, disk_write, next_disk_write;
  logic cache_valid, next_cache_valid, cache_write, next_cache_write;
  logic [`RC_LUNS-1:0] lun_en, next_lun_en;
  logic [`RC_LBA_W-1:0] aligned_lba;

  assign lk.start = start;
  assign lk.key = key_q;
  assign lk.limit = limit;
  assign lk.touch = touch;
  assign lk.fill = fill;
  assign lk.fill_idx = entry;
  assign lk.flush = flush;
  // Entries cover whole aligned block ranges
  assign aligned_lba = {key_q.tag, `RC_ENTRY_SHIFT'(0)};

  rcache_lookup u_rcache_lookup (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .lk(lk)
  );

  // ==========================================================
  // Policy sequencer
  always_comb begin
    next_state = state;
    next_wr_q = wr_q;
    next_disk_ok = disk_ok;
    next_cache_ok = cache_ok;
    next_cfg_ok = cfg_ok;
    next_cache_in_shmem = cache_in_shmem;
    next_ctx_in_shmem = ctx_in_shmem;
    next_key_q = key_q;
    next_limit = limit;
    next_entry = entry;
    next_start = 1'b0;
    next_touch = 1'b0;
    next_fill = 1'b0;
    next_flush = i_power_fail;
    next_host_done = 1'b0;
    next_from_cache = from_cache;
    next_disk_valid = disk_valid;
    next_disk_write = disk_write;
    next_cache_valid = cache_valid;
    next_cache_write = cache_write;
    next_lun_en = lun_en;
    if (i_lun_cfg_valid) begin
      next_lun_en[i_lun_cfg_idx] = i_lun_cfg_enable;
    end
    // Straps are caught once after reset release, not under the reset
    if (!cfg_ok) begin
      next_cfg_ok = 1'b1;
      next_cache_in_shmem = !i_module_present;
      next_ctx_in_shmem = i_module_present;
      if (!i_module_present) begin
        next_limit = cnt_t'(`RC_ENTRIES_SHMEM);
      end else if (i_module_32mb) begin
        next_limit = cnt_t'(`RC_ENTRIES_32MB);
      end else begin
        next_limit = cnt_t'(`RC_ENTRIES_16MB);
      end
    end
    case (state)
      ST_IDLE: begin
        if (req_ready && i_req_valid && !i_power_fail) begin
          next_wr_q = i_req_write;
          next_key_q = '{lun: i_req_lun, tag: i_req_lba[`RC_LBA_W-1:`RC_ENTRY_SHIFT]};
          if (lun_en[i_req_lun]) begin
            next_start = 1'b1;
            next_state = ST_LOOKUP;
          end else begin
            // Disabled unit goes straight to disk and keeps the cache untouched
            next_disk_valid = 1'b1;
            next_disk_write = i_req_write;
            next_state = ST_BYPASS;
          end
        end
      end
      ST_LOOKUP: begin
        if (lk.done) begin
          next_entry = lk.hit ? lk.hit_idx : lk.victim_idx;
          if (wr_q) begin
            next_disk_valid = 1'b1;
            next_disk_write = 1'b1;
            next_cache_valid = 1'b1;
            next_cache_write = 1'b1;
            next_disk_ok = 1'b0;
            next_cache_ok = 1'b0;
            next_state = ST_WRITE;
          end else if (lk.hit) begin
            next_cache_valid = 1'b1;
            next_cache_write = 1'b0;
            next_state = ST_HIT_RD;
          end else begin
            next_disk_valid = 1'b1;
            next_disk_write = 1'b0;
            next_state = ST_MISS_RD;
          end
        end
      end
      ST_HIT_RD: begin
        if (i_cache_done) begin
          next_cache_valid = 1'b0;
          next_host_done = 1'b1;
          next_from_cache = 1'b1;
          next_touch = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_MISS_RD: begin
        if (i_disk_done) begin
          next_disk_valid = 1'b0;
          next_host_done = 1'b1;
          next_from_cache = 1'b0;
          next_cache_valid = 1'b1;
          next_cache_write = 1'b1;
          next_state = ST_FILL;
        end
      end
      ST_FILL: begin
        if (i_cache_done) begin
          next_cache_valid = 1'b0;
          next_fill = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (i_disk_done) begin
          next_disk_valid = 1'b0;
          next_disk_ok = 1'b1;
        end
        if (i_cache_done) begin
          next_cache_valid = 1'b0;
          next_cache_ok = 1'b1;
        end
        if ((disk_ok || i_disk_done) && (cache_ok || i_cache_done)) begin
          next_host_done = 1'b1;
          next_from_cache = 1'b0;
          next_fill = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_BYPASS: begin
        if (i_disk_done) begin
          next_disk_valid = 1'b0;
          next_host_done = 1'b1;
          next_from_cache = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Power loss abandons the transfer so nothing is installed afterwards
    if (i_power_fail) begin
      next_state = ST_IDLE;
      next_disk_valid = 1'b0;
      next_cache_valid = 1'b0;
      next_host_done = 1'b0;
      next_start = 1'b0;
      next_touch = 1'b0;
      next_fill = 1'b0;
    end
    // A start in the flush cycle would be lost in the tag store, so hold requests off
    next_req_ready = (next_state == ST_IDLE) && next_cfg_ok && !i_power_fail;
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= ST_IDLE;
      wr_q <= 1'b0;
      disk_ok <= 1'b0;
      cache_ok <= 1'b0;
      cfg_ok <= 1'b0;
      cache_in_shmem <= 1'b0;
      ctx_in_shmem <= 1'b0;
      key_q <= '0;
      limit <= '0;
      entry <= '0;
      start <= 1'b0;
      touch <= 1'b0;
      fill <= 1'b0;
      flush <= 1'b0;
      req_ready <= 1'b0;
      host_done <= 1'b0;
      from_cache <= 1'b0;
      disk_valid <= 1'b0;
      disk_write <= 1'b0;
      cache_valid <= 1'b0;
      cache_write <= 1'b0;
      lun_en <= '1;
    end else begin
      state <= next_state;
      wr_q <= next_wr_q;
      disk_ok <= next_disk_ok;
      cache_ok <= next_cache_ok;
      cfg_ok <= next_cfg_ok;
      cache_in_shmem <= next_cache_in_shmem;
      ctx_in_shmem <= next_ctx_in_shmem;
      key_q <= next_key_q;
      limit <= next_limit;
      entry <= next_entry;
      start <= next_start;
      touch <= next_touch;
      fill <= next_fill;
      flush <= next_flush;
      req_ready <= next_req_ready;
      host_done <= next_host_done;
      from_cache <= next_from_cache;
      disk_valid <= next_disk_valid;
      disk_write <= next_disk_write;
      cache_valid <= next_cache_valid;
      cache_write <= next_cache_write;
      lun_en <= next_lun_en;
    end
  end

  assign o_req_ready = req_ready;
  assign o_host_done = host_done;
  assign o_host_from_cache = from_cache;
  assign o_disk_cmd_valid = disk_valid;
  assign o_disk_write = disk_write;
  assign o_disk_lba = aligned_lba;
  assign o_cache_cmd_valid = cache_valid;
  assign o_cache_write = cache_write;
  assign o_cache_entry = entry;
  assign o_cache_in_shmem = cache_in_shmem;
  assign o_ctx_in_shmem = ctx_in_shmem;
  assign o_lun_enabled = lun_en;

  chk_hit_no_disk: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (state == ST_LOOKUP && lk.done && lk.hit && !wr_q && !i_power_fail)
    |=> (o_cache_cmd_valid && !o_cache_write && !o_disk_cmd_valid))
    else $error("read hit did not go to cache alone");
  chk_miss_then_fill: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (state == ST_MISS_RD && i_disk_done && !i_power_fail)
    |=> (o_host_done && !o_host_from_cache && o_cache_cmd_valid && o_cache_write))
    else $error("miss data not delivered then filled");
  chk_entry_aligned: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_disk_cmd_valid |-> (o_disk_lba[`RC_ENTRY_SHIFT-1:0] == '0))
    else $error("disk access not entry aligned");
  chk_lun_reset_on: assert property (@(posedge i_ref_clk)
    $fell(i_reset) |-> (o_lun_enabled == '1)) else $error("unit enables not set");
  chk_write_both: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (state == ST_LOOKUP && lk.done && wr_q && !i_power_fail)
    |=> (o_disk_cmd_valid && o_disk_write && o_cache_cmd_valid && o_cache_write))
    else $error("write not sent to disk and cache");
  chk_power_abort: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_power_fail |=> (!o_disk_cmd_valid && !o_cache_cmd_valid && !fill && flush))
    else $error("power loss did not abort and flush");
  chk_store_select: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    cfg_ok |-> (o_cache_in_shmem != o_ctx_in_shmem)) else $error("store select clash");
  chk_module_size: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (cfg_ok && o_ctx_in_shmem) |-> (limit == cnt_t'(`RC_ENTRIES_16MB) ||
    limit == cnt_t'(`RC_ENTRIES_32MB))) else $error("entry count not module sized");
endmodule // host_read_cache_manager

// ---- include/rcache_consts.svh ----
// Constants of the host read cache manager
`ifndef RCACHE_CONSTS_SVH
`define RCACHE_CONSTS_SVH
`define RC_LUNS 16
`define RC_LUN_W 4
`define RC_LBA_W 32
`define RC_BLK_PER_ENTRY 128
`define RC_ENTRY_SHIFT 7
`define RC_ENTRY_KB 64
`define RC_TAG_W (`RC_LBA_W - `RC_ENTRY_SHIFT)
`define RC_MOD16_MB 16
`define RC_MOD32_MB 32
`define RC_ENTRIES_16MB (`RC_MOD16_MB * 1024 / `RC_ENTRY_KB)
`define RC_ENTRIES_32MB (`RC_MOD32_MB * 1024 / `RC_ENTRY_KB)
`define RC_ENTRIES_SHMEM 64
`define RC_MAX_ENTRIES `RC_ENTRIES_32MB
`define RC_IDX_W 9
`define RC_REF_W 8
`define RC_STAMP_W 16
`endif

// ---- include/rcache_pkg.sv ----
// Types of the host read cache manager
`include "rcache_consts.svh"
package rcache_pkg;
  typedef logic [`RC_IDX_W-1:0] idx_t;
  typedef logic [`RC_IDX_W:0] cnt_t;
  typedef struct packed {
    logic [`RC_LUN_W-1:0] lun;
    logic [`RC_TAG_W-1:0] tag;
  } key_s;
  typedef enum logic [2:0] {
    ST_IDLE, ST_LOOKUP, ST_HIT_RD, ST_MISS_RD, ST_FILL, ST_WRITE, ST_BYPASS
  } state_e;
endpackage

// ---- include/rcache_if.sv ----
// Link between the cache policy engine and its tag store
interface rcache_if;
  import rcache_pkg::*;
  logic start;
  rcache_pkg::key_s key;
  rcache_pkg::cnt_t limit;
  logic done;
  logic hit;
  rcache_pkg::idx_t hit_idx;
  rcache_pkg::idx_t victim_idx;
  logic touch;
  logic fill;
  rcache_pkg::idx_t fill_idx;
  logic flush;
  modport engine (output start, key, limit, touch, fill, fill_idx, flush,
                  input done, hit, hit_idx, victim_idx);
  modport lookup (input start, key, limit, touch, fill, fill_idx, flush,
                  output done, hit, hit_idx, victim_idx);
endinterface

// ---- rtl/rcache_lookup.sv ----
// Tag store with scanning hit search and fewest-references victim choice, oldest use on a tie
module rcache_lookup import rcache_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  rcache_if.lookup lk
);
  logic [`RC_MAX_ENTRIES-1:0] valid;
  key_s key_mem [`RC_MAX_ENTRIES];
  logic [`RC_REF_W-1:0] refs [`RC_MAX_ENTRIES];
  logic [`RC_STAMP_W-1:0] stamp [`RC_MAX_ENTRIES];
  logic [`RC_STAMP_W-1:0] use_clock;
  logic busy, next_busy, done, next_done, hit, next_hit, best_free, next_best_free;
  idx_t idx, next_idx, hit_idx, next_hit_idx, best_idx, next_best_idx;
  logic [`RC_REF_W-1:0] best_refs, next_best_refs;
  logic [`RC_STAMP_W-1:0] best_stamp, next_best_stamp;
  logic match;

  assign lk.done = done;
  assign lk.hit = hit;
  assign lk.hit_idx = hit_idx;
  assign lk.victim_idx = best_idx;
  assign match = valid[idx] && (key_mem[idx] == lk.key);

  // ==========================================================
  // Scan
  always_comb begin
    next_busy = busy;
    next_idx = idx;
    next_done = 1'b0;
    next_hit = hit;
    next_hit_idx = hit_idx;
    next_best_free = best_free;
    next_best_idx = best_idx;
    next_best_refs = best_refs;
    next_best_stamp = best_stamp;
    if (lk.flush) begin
      next_busy = 1'b0;
    end else if (!busy) begin
      if (lk.start) begin
        next_busy = 1'b1;
        next_idx = '0;
        next_hit = 1'b0;
        next_best_free = 1'b0;
        next_best_idx = '0;
        next_best_refs = '1;
        next_best_stamp = '1;
      end
    end else begin
      if (match) begin
        next_hit = 1'b1;
        next_hit_idx = idx;
      end else if (!valid[idx] && !best_free) begin
        next_best_free = 1'b1;
        next_best_idx = idx;
      end else if (valid[idx] && !best_free && ((refs[idx] < best_refs) ||
                   ((refs[idx] == best_refs) && (stamp[idx] < best_stamp)))) begin
        // Fewest references first, the oldest use breaks a tie
        next_best_idx = idx;
        next_best_refs = refs[idx];
        next_best_stamp = stamp[idx];
      end
      if (match || ({1'b0, idx} == cnt_t'(lk.limit - cnt_t'(1)))) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_idx = idx_t'(idx + idx_t'(1));
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      busy <= 1'b0;
      idx <= '0;
      done <= 1'b0;
      hit <= 1'b0;
      hit_idx <= '0;
      best_free <= 1'b0;
      best_idx <= '0;
      best_refs <= '0;
      best_stamp <= '0;
    end else begin
      busy <= next_busy;
      idx <= next_idx;
      done <= next_done;
      hit <= next_hit;
      hit_idx <= next_hit_idx;
      best_free <= next_best_free;
      best_idx <= next_best_idx;
      best_refs <= next_best_refs;
      best_stamp <= next_best_stamp;
    end
  end

  // ==========================================================
  // Entry state; only valid bits and the use clock are reset, stale tags never match
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      valid <= '0;
      use_clock <= '0;
    end else if (lk.flush) begin
      valid <= '0;
    end else if (lk.fill) begin
      valid[lk.fill_idx] <= 1'b1;
      key_mem[lk.fill_idx] <= lk.key;
      refs[lk.fill_idx] <= `RC_REF_W'(1);
      stamp[lk.fill_idx] <= use_clock;
      use_clock <= use_clock + `RC_STAMP_W'(1);
    end else if (lk.touch) begin
      if (refs[lk.fill_idx] != '1) begin
        refs[lk.fill_idx] <= refs[lk.fill_idx] + `RC_REF_W'(1);
      end
      stamp[lk.fill_idx] <= use_clock;
      use_clock <= use_clock + `RC_STAMP_W'(1);
    end
  end

  chk_flush_clears: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    lk.flush |=> (valid == '0)) else $error("flush left a valid entry");
  chk_hit_key_match: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (done && hit) |-> (valid[hit_idx] && key_mem[hit_idx] == lk.key))
    else $error("hit reported on mismatching entry");
  chk_free_victim: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (done && !hit && best_free) |-> !valid[best_idx]) else $error("victim not free");
  chk_scan_limit: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    busy |-> ({1'b0, idx} < lk.limit)) else $error("scan past installed entries");
endmodule // rcache_lookup

// ---- verif/rcache_far_side.sv ----
// Disk port and cache store model that answers the manager's commands
`include "rcache_consts.svh"
module rcache_far_side (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [3:0] i_delay,
  input wire logic i_disk_cmd_valid,
  input wire logic i_disk_write,
  input wire logic [`RC_LBA_W-1:0] i_disk_lba,
  input wire logic i_cache_cmd_valid,
  input wire logic i_cache_write,
  input wire logic [`RC_IDX_W-1:0] i_cache_entry,
  output logic o_disk_done,
  output logic o_cache_done,
  output logic [15:0] o_disk_reads,
  output logic [15:0] o_disk_writes,
  output logic [15:0] o_cache_writes,
  output logic [`RC_LBA_W-1:0] o_last_lba,
  output logic [`RC_IDX_W-1:0] o_last_entry
);
  timeunit 1ns;
  timeprecision 100ps;
  logic disk_busy;
  logic cache_busy;
  logic [3:0] disk_wait;
  logic [3:0] cache_wait;
  // ==========================================================
  // Command acceptance and completion
  // The done pulse itself blocks re-acceptance, since valid drops one edge late
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_disk_done <= 1'b0;
      o_cache_done <= 1'b0;
      disk_busy <= 1'b0;
      cache_busy <= 1'b0;
      disk_wait <= 4'h0;
      cache_wait <= 4'h0;
      o_disk_reads <= 16'h0000;
      o_disk_writes <= 16'h0000;
      o_cache_writes <= 16'h0000;
      o_last_lba <= '0;
      o_last_entry <= '0;
    end else begin
      o_disk_done <= 1'b0;
      o_cache_done <= 1'b0;
      if (i_disk_cmd_valid && !disk_busy && !o_disk_done) begin
        disk_busy <= 1'b1;
        disk_wait <= i_delay;
        o_last_lba <= i_disk_lba;
        if (i_disk_write) begin
          o_disk_writes <= o_disk_writes + 16'h0001;
        end else begin
          o_disk_reads <= o_disk_reads + 16'h0001;
        end
      end else if (disk_busy) begin
        if (disk_wait == 4'h0) begin
          o_disk_done <= 1'b1;
          disk_busy <= 1'b0;
        end else begin
          disk_wait <= disk_wait - 4'h1;
        end
      end
      if (i_cache_cmd_valid && !cache_busy && !o_cache_done) begin
        cache_busy <= 1'b1;
        cache_wait <= i_delay;
        o_last_entry <= i_cache_entry;
        if (i_cache_write) begin
          o_cache_writes <= o_cache_writes + 16'h0001;
        end
      end else if (cache_busy) begin
        if (cache_wait == 4'h0) begin
          o_cache_done <= 1'b1;
          cache_busy <= 1'b0;
        end else begin
          cache_wait <= cache_wait - 4'h1;
        end
      end
    end
  end
endmodule // rcache_far_side

// ---- verif/test_host_read_cache_manager.sv ----
// Self-checking bench for the host read cache manager
`include "rcache_consts.svh"
module test_host_read_cache_manager import rcache_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_ref_clk, i_reset, i_power_fail, i_module_present, i_module_32mb;
  logic i_lun_cfg_valid, i_lun_cfg_enable, i_req_valid, i_req_write;
  logic [`RC_LUN_W-1:0] i_lun_cfg_idx, i_req_lun;
  logic [`RC_LBA_W-1:0] i_req_lba, o_disk_lba, last_lba;
  logic o_req_ready, o_host_done, o_host_from_cache, o_disk_cmd_valid, o_disk_write;
  logic i_disk_done, o_cache_cmd_valid, o_cache_write, o_cache_in_shmem;
  logic o_ctx_in_shmem, i_cache_done;
  logic [`RC_IDX_W-1:0] o_cache_entry, last_entry;
  logic [`RC_LUNS-1:0] o_lun_enabled;
  logic [15:0] disk_reads, disk_writes, cache_writes;
  logic [3:0] far_delay;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  host_read_cache_manager u_host_read_cache_manager (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_power_fail(i_power_fail), .i_module_present(i_module_present),
    .i_module_32mb(i_module_32mb), .i_lun_cfg_valid(i_lun_cfg_valid),
    .i_lun_cfg_idx(i_lun_cfg_idx), .i_lun_cfg_enable(i_lun_cfg_enable),
    .i_req_valid(i_req_valid), .i_req_write(i_req_write), .i_req_lun(i_req_lun),
    .i_req_lba(i_req_lba), .o_req_ready(o_req_ready), .o_host_done(o_host_done),
    .o_host_from_cache(o_host_from_cache), .o_disk_cmd_valid(o_disk_cmd_valid),
    .o_disk_write(o_disk_write), .o_disk_lba(o_disk_lba), .i_disk_done(i_disk_done),
    .o_cache_cmd_valid(o_cache_cmd_valid), .o_cache_write(o_cache_write),
    .o_cache_entry(o_cache_entry), .o_cache_in_shmem(o_cache_in_shmem),
    .o_ctx_in_shmem(o_ctx_in_shmem), .i_cache_done(i_cache_done),
    .o_lun_enabled(o_lun_enabled));
  rcache_far_side u_rcache_far_side (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_delay(far_delay), .i_disk_cmd_valid(o_disk_cmd_valid), .i_disk_write(o_disk_write),
    .i_disk_lba(o_disk_lba), .i_cache_cmd_valid(o_cache_cmd_valid),
    .i_cache_write(o_cache_write), .i_cache_entry(o_cache_entry), .o_disk_done(i_disk_done),
    .o_cache_done(i_cache_done), .o_disk_reads(disk_reads), .o_disk_writes(disk_writes),
    .o_cache_writes(cache_writes), .o_last_lba(last_lba), .o_last_entry(last_entry));
  // ==========================================================
  // Clock, hang guard and reporting
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================================
  // Shared drivers
  task automatic do_reset(input logic present, input logic m32);
    i_module_present = present;
    i_module_32mb = m32;
    i_reset = 1'b1;
    repeat (12) @(posedge i_ref_clk);
    #1 i_reset = 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1;
    check("lun enables", o_lun_enabled, 16'hFFFF);
    check("data in shared memory", o_cache_in_shmem, !present);
    check("context in shared memory", o_ctx_in_shmem, present);
  endtask
  // Miss fills are counted only after delivery, so the fill order is visible
  task automatic req(input logic w, input logic [3:0] lun, input logic [31:0] lba,
      input logic hit, input logic [15:0] dr, input logic [15:0] dw, input logic fill);
    logic [15:0] r0;
    logic [15:0] w0;
    logic [15:0] c0;
    int n;
    r0 = disk_reads;
    w0 = disk_writes;
    c0 = cache_writes;
    i_req_valid = 1'b1;
    i_req_write = w;
    i_req_lun = lun;
    i_req_lba = lba;
    n = 0;
    while (o_req_ready !== 1'b1 && n < 1000) begin
      @(posedge i_ref_clk);
      #1 n++;
    end
    // Ready is seen settled, so the next edge is the one that takes the request
    @(posedge i_ref_clk);
    #1 i_req_valid = 1'b0;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      #1 n++;
    end while (o_host_done !== 1'b1 && n < 1000);
    check("host done", o_host_done, 1'b1);
    check("served from cache", o_host_from_cache, hit);
    check("disk reads", disk_reads - r0, dr);
    check("disk writes", disk_writes - w0, dw);
    check("cache writes at delivery", cache_writes - c0, w);
    if (dr != 16'h0000 || dw != 16'h0000) begin
      check("disk offset", last_lba[6:0], 7'h00);
      check("disk entry address", last_lba[31:7], lba[31:7]);
    end
    n = 0;
    do begin
      @(posedge i_ref_clk);
      #1 n++;
    end while (o_req_ready !== 1'b1 && n < 1000);
    check("cache writes after", cache_writes - c0, w | fill);
  endtask
  task automatic set_lun(input logic [3:0] lun, input logic en);
    i_lun_cfg_idx = lun;
    i_lun_cfg_enable = en;
    i_lun_cfg_valid = 1'b1;
    @(posedge i_ref_clk);
    #1 i_lun_cfg_valid = 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1;
  endtask
  // ==========================================================
  // Scenarios
  task automatic s_module();
    do_reset(1'b1, 1'b1);
    req(1'b0, 4'h1, 32'h0000_0105, 1'b0, 16'h0001, 16'h0000, 1'b1);
    req(1'b0, 4'h1, 32'h0000_017F, 1'b1, 16'h0000, 16'h0000, 1'b0);
    req(1'b0, 4'h2, 32'h0000_0100, 1'b0, 16'h0001, 16'h0000, 1'b1);
    req(1'b0, 4'h1, 32'h0000_0180, 1'b0, 16'h0001, 16'h0000, 1'b1);
  endtask
  task automatic s_write();
    req(1'b1, 4'h3, 32'h0000_0400, 1'b0, 16'h0000, 16'h0001, 1'b0);
    req(1'b0, 4'h3, 32'h0000_047F, 1'b1, 16'h0000, 16'h0000, 1'b0);
  endtask
  task automatic s_disable();
    set_lun(4'h1, 1'b0);
    check("unit disabled", o_lun_enabled, 16'hFFFD);
    req(1'b0, 4'h1, 32'h0000_0100, 1'b0, 16'h0001, 16'h0000, 1'b0);
    set_lun(4'h1, 1'b1);
    check("unit enabled", o_lun_enabled, 16'hFFFF);
  endtask
  task automatic s_power();
    i_power_fail = 1'b1;
    @(posedge i_ref_clk);
    #1;
    check("ready during power loss", o_req_ready, 1'b0);
    i_power_fail = 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1;
    req(1'b0, 4'h3, 32'h0000_0400, 1'b0, 16'h0001, 16'h0000, 1'b1);
  endtask
  // Entry 5 is left with the fewest references, so it must be the victim
  task automatic s_lru();
    logic [`RC_IDX_W-1:0] e5;
    logic [`RC_IDX_W-1:0] emax;
    int i;
    do_reset(1'b1, 1'b0);
    req(1'b0, 4'h0, 32'h0000_0000, 1'b0, 16'h0001, 16'h0000, 1'b1);
    do_reset(1'b0, 1'b0);
    far_delay = 4'h0;
    emax = '0;
    for (i = 0; i < 64; i++) begin
      req(1'b0, 4'h0, 32'(i) << 7, 1'b0, 16'h0001, 16'h0000, 1'b1);
      if (i == 5) e5 = last_entry;
      if (last_entry > emax) emax = last_entry;
    end
    check("shared store bound", emax, 9'h03F);
    for (i = 0; i < 64; i++) begin
      if (i != 5) req(1'b0, 4'h0, 32'(i) << 7, 1'b1, 16'h0000, 16'h0000, 1'b0);
    end
    req(1'b0, 4'h0, 32'h0000_2000, 1'b0, 16'h0001, 16'h0000, 1'b1);
    check("victim entry", last_entry, e5);
    req(1'b0, 4'h0, 32'h0000_0000, 1'b1, 16'h0000, 16'h0000, 1'b0);
    req(1'b0, 4'h0, 32'h0000_0280, 1'b0, 16'h0001, 16'h0000, 1'b1);
  endtask
  initial begin
    i_reset = 1'b1;
    i_power_fail = 1'b0;
    i_module_present = 1'b0;
    i_module_32mb = 1'b0;
    i_lun_cfg_valid = 1'b0;
    i_lun_cfg_idx = 4'h0;
    i_lun_cfg_enable = 1'b1;
    i_req_valid = 1'b0;
    i_req_write = 1'b0;
    i_req_lun = 4'h0;
    i_req_lba = 32'h0000_0000;
    far_delay = 4'h5;
    s_module();
    s_write();
    s_disable();
    s_power();
    s_lru();
    complete_run();
  end
endmodule // test_host_read_cache_manager
